/* dbm_top.sv */
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dbm_cfg.svh"
module dbm_top (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // access from the core
  input wire logic acc_valid_i,
  input wire logic [31:0] acc_addr_i,
  input wire logic acc_dma_i,
  input wire logic acc_instr_i,
  input wire logic acc_super_i,
  // phase strobes from the timing logic
  input wire logic row_phase_i,
  input wire logic col_phase_i,
  // decoded results
  output logic res_valid_o,
  output logic [3:0] bank_sel_o,
  output logic [31:0] phys_addr_o,
  output logic map_miss_o,
  output dbm_pkg::dbm_miss_t miss_kind_o,
  output logic page_ok_o,
  output logic [8:0] refresh_interval_count_o,
  output logic [13:0] dram_addr_o
);
  // register state
  logic [31:0] ctrl_reg, ctrl_next; // control: page, width, mode, refresh
  logic [31:0] conf_reg, conf_next; // per-bank select and mask
  logic [31:0] map_reg [4]; // mapping slots, no reset
  logic [31:0] map_next [4];
  logic [3:0] map_we; // per-slot write enable
  // axi state
  dbm_pkg::dbm_wr_t wr_reg, wr_next;
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [31:0] awaddr_reg, awaddr_next, wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  // access result state
  logic res_valid_reg, res_valid_next;
  logic [3:0] bank_reg, bank_next;
  logic [31:0] phys_reg, phys_next;
  logic miss_reg, miss_next;
  dbm_pkg::dbm_miss_t kind_reg, kind_next;
  logic page_reg, page_next;
  logic wide_reg, wide_next; // selected bank is 32 bits
  logic [13:0] pin_reg, pin_next;
  logic [1:0] slot_reg, slot_next; // slot used by last mapping
  logic [31:0] status_w;
  dbm_mux_if mx ();

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // address known to the slave
  function automatic logic hit_map(input logic [31:0] a);
    return (a == `DBM_CTRL_ADDR) || (a == `DBM_CONF_ADDR) || (a == `DBM_MAP0_ADDR)
      || (a == `DBM_MAP1_ADDR) || (a == `DBM_MAP2_ADDR) || (a == `DBM_MAP3_ADDR)
      || (a == `DBM_STAT_ADDR);
  endfunction

  // bank decode: unmasked select bits against upper address bits
  function automatic logic bank_hit(input logic [7:0] f, input logic lm,
                                    input logic [31:0] a);
    logic [4:0] ad;
    logic [4:0] care;
    ad = lm ? a[25:21] : a[23:19];
    care = {2'h3, ~f[2], ~f[1], ~f[0]};
    return ((f[7:3] ^ ad) & care) == 5'h00;
  endfunction

  assign status_w = {24'h000000, miss_reg, wide_reg, slot_reg, bank_reg};

  // write channel: address and data taken in either order
  always_comb begin
    wr_next = wr_reg;
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    awready_next = awready_reg;
    wready_next = wready_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    ctrl_next = ctrl_reg;
    conf_next = conf_reg;
    map_we = 4'h0;
    for (int k = 0; k < 4; k++) begin
      map_next[k] = merge(map_reg[k], wdata_reg, wstrb_reg);
    end
    case (wr_reg)
      dbm_pkg::DBM_WR_COLLECT: begin
        if (s_axi_awvalid && awready_reg) begin
          aw_got_next = 1'b1;
          awaddr_next = s_axi_awaddr;
          awready_next = 1'b0;
        end
        if (s_axi_wvalid && wready_reg) begin
          w_got_next = 1'b1;
          wdata_next = s_axi_wdata;
          wstrb_next = s_axi_wstrb;
          wready_next = 1'b0;
        end
        if (aw_got_reg && w_got_reg) begin
          // commit the word
          wr_next = dbm_pkg::DBM_WR_RESP;
          bvalid_next = 1'b1;
          bresp_next = hit_map(awaddr_reg) ? `DBM_RESP_OK : `DBM_RESP_ERR;
          if (awaddr_reg == `DBM_CTRL_ADDR) begin
            ctrl_next = merge(ctrl_reg, wdata_reg, wstrb_reg);
          end
          if (awaddr_reg == `DBM_CONF_ADDR) begin
            conf_next = merge(conf_reg, wdata_reg, wstrb_reg);
          end
          map_we = {awaddr_reg == `DBM_MAP3_ADDR, awaddr_reg == `DBM_MAP2_ADDR,
                    awaddr_reg == `DBM_MAP1_ADDR, awaddr_reg == `DBM_MAP0_ADDR};
        end
      end
      dbm_pkg::DBM_WR_RESP: begin
        if (s_axi_bready) begin
          // answer taken, reopen both channels
          wr_next = dbm_pkg::DBM_WR_COLLECT;
          bvalid_next = 1'b0;
          aw_got_next = 1'b0;
          w_got_next = 1'b0;
          awready_next = 1'b1;
          wready_next = 1'b1;
        end
      end
      default: wr_next = dbm_pkg::DBM_WR_COLLECT;
    endcase
  end

  // read channel: one cycle to data
  always_comb begin
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = hit_map(s_axi_araddr) ? `DBM_RESP_OK : `DBM_RESP_ERR;
      case (s_axi_araddr)
        `DBM_CTRL_ADDR: rdata_next = ctrl_reg;
        `DBM_CONF_ADDR: rdata_next = conf_reg;
        `DBM_MAP0_ADDR: rdata_next = map_reg[0];
        `DBM_MAP1_ADDR: rdata_next = map_reg[1];
        `DBM_MAP2_ADDR: rdata_next = map_reg[2];
        `DBM_MAP3_ADDR: rdata_next = map_reg[3];
        `DBM_STAT_ADDR: rdata_next = status_w;
        default: rdata_next = 32'h00000000;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
  end

  // access decode: mapping, bank select, page check
  always_comb begin
    logic [31:0] a;
    logic mapped;
    logic found;
    logic [3:0] hits;
    a = acc_addr_i;
    mapped = (acc_addr_i[31:24] == `DBM_WIN_HI) && !acc_dma_i;
    found = 1'b0;
    hits = 4'h0;
    slot_next = slot_reg;
    res_valid_next = acc_valid_i;
    bank_next = bank_reg;
    phys_next = phys_reg;
    miss_next = miss_reg;
    kind_next = kind_reg;
    page_next = 1'b0;
    wide_next = wide_reg;
    if (acc_valid_i) begin
      if (mapped) begin
        // lowest valid slot that matches wins
        for (int k = 3; k >= 0; k--) begin
          if (map_reg[k][`DBM_VALID_BIT] && (map_reg[k][23:16] == acc_addr_i[23:16])) begin
            found = 1'b1;
            slot_next = 2'(k);
            a = {`DBM_DRAM_HI, map_reg[k][7:0], acc_addr_i[15:0]};
          end
        end
      end
      for (int b = 0; b < 4; b++) begin
        hits[b] = bank_hit(conf_reg[31 - 8*b -: 8], ctrl_reg[`DBM_LM_BIT], a);
      end
      miss_next = mapped && !found;
      kind_next = dbm_pkg::dbm_miss_t'({acc_super_i, !acc_instr_i});
      bank_next = 4'h0;
      if (!(mapped && !found)) begin
        // lowest-numbered bank on overlap
        for (int b = 3; b >= 0; b--) begin
          if (hits[b]) begin
            bank_next = 4'h0;
            bank_next[b] = 1'b1;
            wide_next = !ctrl_reg[30 - 4*b];
          end
        end
      end
      phys_next = a;
      // page continues: same bank, page enabled, same 1-Kbyte block
      for (int b = 0; b < 4; b++) begin
        if (bank_next[b] && bank_reg[b] && ctrl_reg[31 - 4*b] && !miss_reg
            && (a[31:10] == phys_reg[31:10])) begin
          page_next = 1'b1;
        end
      end
    end
  end

  // pin drive follows the strobes, row first
  assign mx.phys = phys_reg;
  assign mx.wide32 = wide_reg;
  assign mx.clk = core_clk_i; // clocks the checks inside the mux
  always_comb begin
    pin_next = pin_reg;
    if (row_phase_i) begin
      pin_next = mx.row;
    end else if (col_phase_i) begin
      pin_next = mx.col;
    end
  end

  dbm_addr_mux u_mux (
    .m(mx)
  );

  // registers with reset
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_reg <= dbm_pkg::DBM_WR_COLLECT;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 32'h00000000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `DBM_RESP_OK;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `DBM_RESP_OK;
      ctrl_reg <= `DBM_CTRL_RST;
      conf_reg <= 32'h00000000;
      res_valid_reg <= 1'b0;
      bank_reg <= 4'h0;
      phys_reg <= 32'h00000000;
      miss_reg <= 1'b0;
      kind_reg <= dbm_pkg::DBM_MISS_USER_INSTR;
      page_reg <= 1'b0;
      wide_reg <= 1'b0;
      pin_reg <= 14'h0000;
      slot_reg <= 2'h0;
    end else begin
      wr_reg <= wr_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      ctrl_reg <= ctrl_next;
      conf_reg <= conf_next;
      res_valid_reg <= res_valid_next;
      bank_reg <= bank_next;
      phys_reg <= phys_next;
      miss_reg <= miss_next;
      kind_reg <= kind_next;
      page_reg <= page_next;
      wide_reg <= wide_next;
      pin_reg <= pin_next;
      slot_reg <= slot_next;
    end
  end

  // mapping slots keep their contents through reset
  always_ff @(posedge core_clk_i) begin
    for (int k = 0; k < 4; k++) begin
      if (map_we[k]) begin
        map_reg[k] <= map_next[k];
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign res_valid_o = res_valid_reg;
  assign bank_sel_o = bank_reg;
  assign phys_addr_o = phys_reg;
  assign map_miss_o = miss_reg;
  assign miss_kind_o = kind_reg;
  assign page_ok_o = page_reg;
  assign refresh_interval_count_o = ctrl_reg[8:0];
  assign dram_addr_o = pin_reg;

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence both_taken_s;
    aw_got_reg && w_got_reg && (wr_reg == dbm_pkg::DBM_WR_COLLECT);
  endsequence
  sequence answer_s;
    s_axi_bvalid [*1];
  endsequence
  bank_onehot_a: assert property (res_valid_o |-> $onehot0(bank_sel_o))
    else $error("more than one bank selected");
  miss_nobank_a: assert property (map_miss_o |-> bank_sel_o == 4'h0)
    else $error("bank selected on mapping miss");
  dma_unmapped_a: assert property (acc_valid_i && acc_dma_i |=> !map_miss_o)
    else $error("dma access raised a mapping miss");
  invalid_miss_a: assert property (acc_valid_i && !acc_dma_i
    && (acc_addr_i[31:24] == `DBM_WIN_HI)
    && !(map_reg[0][31] && (map_reg[0][23:16] == acc_addr_i[23:16]))
    && !(map_reg[1][31] && (map_reg[1][23:16] == acc_addr_i[23:16]))
    && !(map_reg[2][31] && (map_reg[2][23:16] == acc_addr_i[23:16]))
    && !(map_reg[3][31] && (map_reg[3][23:16] == acc_addr_i[23:16])) |=> map_miss_o)
    else $error("invalid slots used for mapping");
  slot0_subst_a: assert property (acc_valid_i && !acc_dma_i
    && (acc_addr_i[31:24] == `DBM_WIN_HI) && map_reg[0][31]
    && (map_reg[0][23:16] == acc_addr_i[23:16])
    |=> (phys_addr_o[23:16] == $past(map_reg[0][7:0])) && (slot_reg == 2'h0))
    else $error("slot zero not substituted");
  page_block_a: assert property (page_ok_o |-> phys_addr_o[31:10] == $past(phys_addr_o[31:10]))
    else $error("page run left its block");
  row_drive_a: assert property (row_phase_i |=> dram_addr_o == $past(mx.row))
    else $error("row not driven on row strobe");
  col_drive_a: assert property (!row_phase_i && col_phase_i |=> dram_addr_o == $past(mx.col))
    else $error("column not driven on column strobe");
  write_answer_a: assert property (both_taken_s |=> answer_s)
    else $error("no write answer after both channels");
endmodule
`default_nettype wire

/* dbm_cfg.svh */
`ifndef DBM_CFG_SVH
`define DBM_CFG_SVH
`define DBM_CTRL_ADDR 32'h80000008
`define DBM_CONF_ADDR 32'h8000000c
`define DBM_MAP0_ADDR 32'h80000010
`define DBM_MAP1_ADDR 32'h80000014
`define DBM_MAP2_ADDR 32'h80000018
`define DBM_MAP3_ADDR 32'h8000001c
`define DBM_STAT_ADDR 32'h80000020
`define DBM_CTRL_RST 32'h000001ff
`define DBM_REFRESH_RST 9'h1ff
`define DBM_LM_BIT 28
`define DBM_VALID_BIT 31
`define DBM_WIN_HI 8'h50
`define DBM_DRAM_HI 8'h40
`define DBM_RESP_OK 2'h0
`define DBM_RESP_ERR 2'h2
`endif

/* dbm_pkg.sv */
package dbm_pkg;
  // kind of mapping miss trap raised
  typedef enum logic [1:0] {
    DBM_MISS_USER_INSTR,
    DBM_MISS_USER_DATA,
    DBM_MISS_SUP_INSTR,
    DBM_MISS_SUP_DATA
  } dbm_miss_t;
  // write channel progress
  typedef enum logic [1:0] {
    DBM_WR_COLLECT,
    DBM_WR_RESP
  } dbm_wr_t;
endpackage

/* dbm_mux_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dbm_mux_if;
  logic [31:0] phys; // physical access address
  logic wide32; // bank is 32 bits wide
  logic [13:0] row; // row value, index 0 is A1
  logic [13:0] col; // column value
  logic clk; // core clock, only for the pin checks
  modport src (output phys, output wide32, output clk, input row, input col);
  modport mux (input phys, input wide32, input clk, output row, output col);
endinterface
`default_nettype wire

/* dbm_addr_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module dbm_addr_mux (
  dbm_mux_if.mux m
);
  genvar i;
  // low nine pins: bit zero of the address never used
  generate
    for (i = 0; i < 9; i++) begin : g_low
      // 16-bit: A1..A9 row a10..a18, col a1..a9; 32-bit: A2..A10 row a11..a19
      assign m.row[i] = m.wide32 ? ((i == 0) ? 1'b0 : m.phys[10 + i]) : m.phys[10 + i];
      assign m.col[i] = m.wide32 ? ((i == 0) ? 1'b0 : m.phys[1 + i]) : m.phys[1 + i];
    end
  endgenerate
  // A10 only for 32-bit banks
  assign m.row[9] = m.wide32 ? m.phys[19] : 1'b0;
  assign m.col[9] = m.wide32 ? m.phys[10] : 1'b0;
  // odd upper pins for 16-bit, even for 32-bit
  assign m.row[10] = m.wide32 ? 1'b0 : m.phys[19];
  assign m.col[10] = m.wide32 ? 1'b0 : m.phys[20];
  assign m.row[11] = m.wide32 ? m.phys[20] : 1'b0;
  assign m.col[11] = m.wide32 ? m.phys[21] : 1'b0;
  assign m.row[12] = m.wide32 ? 1'b0 : m.phys[21];
  assign m.col[12] = m.wide32 ? 1'b0 : m.phys[22];
  assign m.row[13] = m.wide32 ? m.phys[22] : 1'b0;
  assign m.col[13] = m.wide32 ? m.phys[23] : 1'b0;

  // 16-bit banks leave even upper pins quiet: row A10 and A14, column A12
  even_idle_a: assert property (@(posedge m.clk)
    !m.wide32 |-> (m.row[13] == 1'b0) && (m.col[11] == 1'b0)
    && (m.row[9] == 1'b0)) else $error("even upper pin used by 16-bit bank");
  // 32-bit banks leave A1 quiet in both phases
  a1_idle_a: assert property (@(posedge m.clk)
    m.wide32 |-> (m.row[0] == 1'b0) && (m.col[0] == 1'b0)
    && (m.col[12] == 1'b0)) else $error("odd pin used by 32-bit bank");
endmodule
`default_nettype wire

/* dbm_dram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dbm_dram_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic row_strobe_i,
  input wire logic col_strobe_i,
  input wire logic [13:0] pins_i,
  output logic [13:0] row_o,
  output logic [13:0] col_o
);
  logic ras_reg; // row strobe seen at last edge
  logic cas_reg; // column strobe seen at last edge
  // chips latch the pins only while a strobe has been held a cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ras_reg <= 1'b0;
      cas_reg <= 1'b0;
      row_o <= 14'h0;
      col_o <= 14'h0;
    end else begin
      ras_reg <= row_strobe_i;
      cas_reg <= col_strobe_i;
      if (ras_reg) begin
        row_o <= pins_i;
      end else if (cas_reg) begin
        col_o <= pins_i;
      end
    end
  end
endmodule
`default_nettype wire

/* dbm_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dbm_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module dbm_top_test;
  logic core_clk_i, rst_b_i;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, acc_addr_i, phys_addr_o;
  logic [3:0] s_axi_wstrb, bank_sel_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic acc_valid_i, acc_dma_i, acc_instr_i, acc_super_i, row_phase_i, col_phase_i;
  logic res_valid_o, map_miss_o, page_ok_o;
  dbm_pkg::dbm_miss_t miss_kind_o;
  logic [8:0] refresh_interval_count_o;
  logic [13:0] dram_addr_o, row_seen, col_seen;
  logic [31:0] rd; // read data capture
  int fails, n_compared, cyc;
  // bank decode table: address and expected one-hot bank, or zero where no bank hits
  logic [31:0] ba [9] = '{32'h40400000, 32'h407ffffc, 32'h40000000, 32'h401ffffc,
    32'h40200000, 32'h402ffffc, 32'h40300000, 32'h40380000, 32'h40800000};
  logic [3:0] bs [9] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h0, 4'h0};
  // mapping slots: two equal virtual bases, one invalid
  logic [31:0] sv [4] = '{32'h80120005, 32'h80120006, 32'h00340007, 32'h8056003f};

  dbm_top dbm_top_inst (.core_clk_i, .rst_b_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .acc_valid_i, .acc_addr_i, .acc_dma_i, .acc_instr_i,
    .acc_super_i, .row_phase_i, .col_phase_i, .res_valid_o, .bank_sel_o, .phys_addr_o,
    .map_miss_o, .miss_kind_o, .page_ok_o, .refresh_interval_count_o, .dram_addr_o);

  dbm_dram_model dbm_dram_model_inst (.clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .row_strobe_i(row_phase_i), .col_strobe_i(col_phase_i), .pins_i(dram_addr_o),
    .row_o(row_seen), .col_o(col_seen));

  // free-running clock
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  // expected pin values, even/odd upper pins per width
  function automatic logic [13:0] rowx(input logic [31:0] a, input logic w);
    rowx = w ? {a[22], 1'b0, a[20], 1'b0, a[19:11], 1'b0}
             : {1'b0, a[21], 1'b0, a[19], 1'b0, a[18:10]};
  endfunction
  function automatic logic [13:0] colx(input logic [31:0] a, input logic w);
    colx = w ? {a[23], 1'b0, a[21], 1'b0, a[10:2], 1'b0}
             : {1'b0, a[22], 1'b0, a[20], 1'b0, a[9:1]};
  endfunction

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  // one axi write, address and data offered together
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ga, gw, gb;
    gb = 1'b0;
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!gb) begin
      @(negedge core_clk_i);
      ga = s_axi_awvalid && s_axi_awready;
      gw = s_axi_wvalid && s_axi_wready;
      gb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge core_clk_i);
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  // one axi read
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic gr, gd;
    gd = 1'b0;
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!gd) begin
      @(negedge core_clk_i);
      gr = s_axi_arvalid && s_axi_arready;
      gd = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk_i);
      if (gr) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic wrc(input logic [31:0] a, input logic [31:0] d);
    axi_wr(a, d, rs);
    `CHK(rs, `DBM_RESP_OK)
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    axi_rd(a, rd, rs);
    `CHK(rs, er)
    `CHK(rd, e)
  endtask

  // one core access, results looked at mid-cycle
  task automatic acc(input logic [31:0] a, input logic i, input logic s, input logic dm);
    @(posedge core_clk_i);
    acc_valid_i <= 1'b1;
    acc_addr_i <= a;
    acc_instr_i <= i;
    acc_super_i <= s;
    acc_dma_i <= dm;
    @(posedge core_clk_i);
    acc_valid_i <= 1'b0;
    @(negedge core_clk_i);
    `CHK(res_valid_o, 1'b1)
  endtask

  // row phase then column phase, chips report what they latched
  task automatic mux_chk(input logic [31:0] a, input logic w);
    logic [13:0] m;
    m = w ? 14'h2bfe : 14'h15ff;
    acc(a, 1'b0, 1'b0, 1'b0);
    @(posedge core_clk_i);
    row_phase_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    row_phase_i <= 1'b0;
    col_phase_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    col_phase_i <= 1'b0;
    @(negedge core_clk_i);
    `CHK(row_seen & m, rowx(a, w))
    `CHK(col_seen & m, colx(a, w))
  endtask

  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, acc_addr_i} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {acc_valid_i, acc_dma_i, acc_instr_i, acc_super_i, row_phase_i, col_phase_i} = '0;
    s_axi_wstrb = 4'hf;
    rst_b_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rdc(`DBM_CTRL_ADDR, 32'h000001ff, `DBM_RESP_OK);
    `CHK(refresh_interval_count_o, 9'h1ff)
    rdc(32'h80000030, 32'h0, `DBM_RESP_ERR);
    axi_wr(32'h80000030, 32'h1, rs);
    `CHK(rs, `DBM_RESP_ERR)
    $display("test reset done");
    // bank0 page mode, bank1 16-bit, refresh a5
    wrc(`DBM_CTRL_ADDR, 32'h840000a5);
    `CHK(refresh_interval_count_o, 9'h0a5)
    wrc(`DBM_CONF_ADDR, 32'h471b2130);
    for (int k = 0; k < 9; k++) begin
      acc(ba[k], 1'b0, 1'b0, 1'b0);
      `CHK(bank_sel_o, bs[k])
      `CHK(phys_addr_o, ba[k])
    end
    $display("test bank decode done");
    wrc(`DBM_CTRL_ADDR, 32'h940000a5);
    acc(32'h40c00000, 1'b0, 1'b0, 1'b0);
    `CHK(bank_sel_o, 4'h8)
    wrc(`DBM_CTRL_ADDR, 32'h840000a5);
    wrc(`DBM_CONF_ADDR, 32'h471b21f8);
    acc(32'h40f80000, 1'b0, 1'b0, 1'b0);
    `CHK(bank_sel_o, 4'h8)
    $display("test large memory done");
    mux_chk(32'h401a5b6f, 1'b0);
    mux_chk(32'h406d3a95, 1'b1);
    $display("test address mux done");
    acc(32'h404003fc, 1'b1, 1'b0, 1'b0);
    acc(32'h404003fe, 1'b1, 1'b0, 1'b0);
    `CHK(page_ok_o, 1'b1)
    acc(32'h40400400, 1'b1, 1'b0, 1'b0);
    `CHK(page_ok_o, 1'b0)
    $display("test page done");
    for (int k = 0; k < 4; k++) begin
      wrc(`DBM_MAP0_ADDR + 4 * k, sv[k]);
      rdc(`DBM_MAP0_ADDR + 4 * k, sv[k], `DBM_RESP_OK);
    end
    acc(32'h5012abcc, 1'b0, 1'b0, 1'b0);
    `CHK(phys_addr_o, 32'h4005abcc)
    `CHK(map_miss_o, 1'b0)
    `CHK(bank_sel_o, 4'h2)
    acc(32'h50560010, 1'b0, 1'b1, 1'b0);
    `CHK(phys_addr_o, 32'h403f0010)
    for (int k = 0; k < 4; k++) begin
      acc(32'h50340000, ~k[0], k[1], 1'b0);
      `CHK(map_miss_o, 1'b1)
      `CHK(miss_kind_o, dbm_pkg::dbm_miss_t'(k[1:0]))
    end
    acc(32'h5012abcc, 1'b0, 1'b0, 1'b1);
    `CHK(map_miss_o, 1'b0)
    `CHK(phys_addr_o, 32'h5012abcc)
    wrc(`DBM_MAP2_ADDR, 32'h80340007);
    acc(32'h50340000, 1'b0, 1'b0, 1'b0);
    `CHK(phys_addr_o, 32'h40070000)
    rdc(`DBM_STAT_ADDR, 32'h00000022, `DBM_RESP_OK);
    $display("test mapping done");
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rdc(`DBM_MAP0_ADDR, sv[0], `DBM_RESP_OK);
    rdc(`DBM_CTRL_ADDR, 32'h000001ff, `DBM_RESP_OK);
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
